// ===== svdet_consts.svh
// Offsets, field positions, reset values and timing counts of the voltage monitor block.
// Included by the design and the bench; definitions only.
`ifndef SVDET_CONSTS_SVH
`define SVDET_CONSTS_SVH
`define ADDR_PROT 4'h0
`define ADDR_CLK 4'h1
`define ADDR_CTL 4'h2
`define ADDR_FLAG 4'h3
`define ADDR_IRQEN 4'h4
`define UNLOCK_KEY 16'h0096
`define RESET_KEY 4'ha
`define CLK_DEBUG_RUN_POS 8
`define CLK_DIV_POS 4
`define CLK_SRC_POS 0
`define CTL_SRC_POS 15
`define CTL_CNT_POS 13
`define CTL_THR_POS 8
`define CTL_RST_POS 4
`define CTL_EXT_POS 3
`define CTL_MODE_POS 1
`define CTL_EN_POS 0
`define FLAG_RES_POS 1
`define FLAG_IF_POS 0
`define DEBUG_RUN_RST 1'b1
`define THR_RST 5'h1e
`define PER_M1 10'h07f
`define PER_M2 10'h0ff
`define PER_M3 10'h1ff
`endif

// ===== svdet_pkg.sv
// Types shared by the voltage monitor control block.
// Assumes the constants header is available on the include path.
package svdet_pkg;
  typedef enum logic [1:0] {
    mode_cont = 2'b00,
    mode_i128 = 2'b01,
    mode_i256 = 2'b10,
    mode_i512 = 2'b11
  } mode_e;
  typedef struct packed {
    logic src;
    logic [1:0] cnt;
    logic [4:0] thr;
    logic [3:0] rst;
    logic ext;
    mode_e mode;
    logic en;
  } ctl_s;
  typedef struct packed {
    logic debug_run;
    logic [2:0] div;
    logic [1:0] src;
  } clk_s;
endpackage : svdet_pkg

// ===== svdet.sv
// Control logic of a supply voltage detector channel: registers, mode timing, flag and reset.
// Assumes the analog comparator gives a below-threshold level on cmp_low_i and that the
// divided detector clock arrives as a one-cycle tick on det_tick_i from the clock generator.
`timescale 1ns/100ps
`include "svdet_consts.svh"
module svdet
  import svdet_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port.
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // System state and detector clock.
  input wire logic det_tick_i,
  input wire logic sleep_stop_i,
  input wire logic debug_i,
  // Comparator, asynchronous level.
  input wire logic cmp_low_i,
  // Analog control and events.
  output logic cmp_on_o,
  output logic [4:0] thr_o,
  output logic src_ext_o,
  output logic ext_sel_o,
  output logic [1:0] clk_src_o,
  output logic [2:0] clk_div_o,
  output logic irq_o,
  output logic sys_rst_o
);
  logic [15:0] prot_r;
  clk_s clk_r;
  ctl_s ctl_r;
  logic flag_r;
  logic irq_en_r;
  logic result_r;
  logic [2:0] cmp_sync_r;
  logic cmp_low;
  logic run;
  logic tick;
  logic [9:0] per_r;
  logic [9:0] per_max;
  logic [3:0] hits_r;
  logic [3:0] hits_need;
  logic sample;
  logic low_event;
  logic unlocked;
  logic wr_prot;

  assign unlocked = (prot_r == `UNLOCK_KEY);
  assign wr_prot = wr_i && unlocked;

  // Three flops; a change counts only once the last two agree.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_sync_r <= 3'h0;
    end else begin
      cmp_sync_r <= {cmp_sync_r[1:0], cmp_low_i};
    end
  end

  logic cmp_low_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_low_r <= 1'b0;
    end else if (cmp_sync_r[2] == cmp_sync_r[1]) begin
      cmp_low_r <= cmp_sync_r[2];
    end
  end
  assign cmp_low = cmp_low_r;

  // Ticks stop in sleep with the clock-stop set and in debug without debug-run.
  assign run = !(sleep_stop_i) && !(debug_i && !clk_r.debug_run);
  assign tick = det_tick_i && run;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prot_r <= 16'h0000;
    end else if (wr_i && addr_i == `ADDR_PROT) begin
      prot_r <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      clk_r <= '{debug_run: `DEBUG_RUN_RST, div: 3'h0, src: 2'h0};
    end else if (wr_prot && addr_i == `ADDR_CLK) begin
      clk_r.debug_run <= wdata_i[`CLK_DEBUG_RUN_POS];
      clk_r.div <= wdata_i[`CLK_DIV_POS +: 3];
      clk_r.src <= wdata_i[`CLK_SRC_POS +: 2];
    end
  end

  // A detector reset forces continuous mode and clears the count field.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_r <= '{src: 1'b0, cnt: 2'h0, thr: `THR_RST, rst: 4'h0, ext: 1'b0,
                 mode: mode_cont, en: 1'b0};
    end else if (sys_rst_o) begin
      ctl_r.mode <= mode_cont;
      ctl_r.cnt <= 2'h0;
    end else if (wr_prot && addr_i == `ADDR_CTL) begin
      ctl_r.src <= wdata_i[`CTL_SRC_POS];
      if (wdata_i[`CTL_MODE_POS +: 2] != 2'h0) begin
        ctl_r.cnt <= wdata_i[`CTL_CNT_POS +: 2];
      end
      ctl_r.thr <= wdata_i[`CTL_THR_POS +: 5];
      ctl_r.rst <= wdata_i[`CTL_RST_POS +: 4];
      ctl_r.ext <= wdata_i[`CTL_EXT_POS];
      ctl_r.mode <= mode_e'(wdata_i[`CTL_MODE_POS +: 2]);
      ctl_r.en <= wdata_i[`CTL_EN_POS];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_en_r <= 1'b0;
    end else if (sys_rst_o) begin
      irq_en_r <= 1'b0;
    end else if (wr_i && addr_i == `ADDR_IRQEN) begin
      irq_en_r <= wdata_i[0];
    end
  end

  always_comb begin
    unique case (ctl_r.mode)
      mode_cont: per_max = 10'h000;
      mode_i128: per_max = `PER_M1;
      mode_i256: per_max = `PER_M2;
      mode_i512: per_max = `PER_M3;
    endcase
  end

  // The interval counter keeps its place across a change between interval modes; a count beyond the
  // new end wraps on the next tick, so the first interval after a change may run long.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      per_r <= 10'h000;
    end else if (!ctl_r.en || ctl_r.mode == mode_cont) begin
      per_r <= 10'h000;
    end else if (tick) begin
      per_r <= (per_r >= per_max) ? 10'h000 : per_r + 10'h001;
    end
  end

  // Continuous mode follows the comparator directly, even without ticks.
  assign sample = ctl_r.en && ((ctl_r.mode == mode_cont) ||
                  (tick && per_r == per_max));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmp_on_o <= 1'b0;
    end else begin
      cmp_on_o <= ctl_r.en && ((ctl_r.mode == mode_cont) ||
                  (tick && per_r == per_max - 10'h001) || (per_r == per_max));
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      result_r <= 1'b0;
    end else if (sample) begin
      result_r <= cmp_low;
    end
  end

  always_comb begin
    unique case (ctl_r.cnt)
      2'h0: hits_need = 4'h1;
      2'h1: hits_need = 4'h2;
      2'h2: hits_need = 4'h4;
      2'h3: hits_need = 4'h8;
    endcase
  end

  // Hits saturate at the target so that a long low spell keeps raising events.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hits_r <= 4'h0;
    end else if (!ctl_r.en || ctl_r.mode == mode_cont) begin
      hits_r <= 4'h0;
    end else if (sample) begin
      hits_r <= !cmp_low ? 4'h0 : (hits_r >= hits_need) ? hits_r : hits_r + 4'h1;
    end
  end

  assign low_event = sample && cmp_low && ((ctl_r.mode == mode_cont) ||
                     (hits_r + 4'h1 >= hits_need));

  // A new event wins over a clear written in the same cycle.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_r <= 1'b0;
    end else if (low_event) begin
      flag_r <= 1'b1;
    end else if (wr_i && addr_i == `ADDR_FLAG && wdata_i[`FLAG_IF_POS]) begin
      flag_r <= 1'b0;
    end
  end

  // The reset holds until the voltage recovers.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sys_rst_o <= 1'b0;
    end else if (low_event && ctl_r.rst == `RESET_KEY) begin
      sys_rst_o <= 1'b1;
    end else if (sample && !cmp_low) begin
      sys_rst_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= flag_r && irq_en_r && ctl_r.rst != `RESET_KEY;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      thr_o <= `THR_RST;
      src_ext_o <= 1'b0;
      ext_sel_o <= 1'b0;
      clk_src_o <= 2'h0;
      clk_div_o <= 3'h0;
    end else begin
      thr_o <= ctl_r.thr;
      src_ext_o <= ctl_r.src;
      ext_sel_o <= ctl_r.ext;
      clk_src_o <= clk_r.src;
      clk_div_o <= clk_r.div;
    end
  end

  // Read data stand for one cycle only, so a master that looks late sees zero.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      unique case (addr_i)
        `ADDR_PROT: rdata_o <= {15'h0000, unlocked};
        `ADDR_CLK: rdata_o <= {7'h00, clk_r.debug_run, 1'b0, clk_r.div, 2'h0, clk_r.src};
        `ADDR_CTL: rdata_o <= {ctl_r.src, ctl_r.cnt, ctl_r.thr, ctl_r.rst, ctl_r.ext,
                               ctl_r.mode, ctl_r.en};
        `ADDR_FLAG: rdata_o <= {14'h0000, result_r, flag_r};
        `ADDR_IRQEN: rdata_o <= {15'h0000, irq_en_r};
        default: rdata_o <= 16'h0000;
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end

  a_locked_ignore: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_i && !unlocked && addr_i == `ADDR_CTL) |=> $stable(ctl_r))
    else $error("Control changed while locked.");
  a_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    (flag_r && !(wr_i && addr_i == `ADDR_FLAG && wdata_i[0])) |=> flag_r)
    else $error("Flag dropped without a clear.");
  a_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o |-> $past(flag_r) && $past(irq_en_r))
    else $error("Interrupt without flag and enable.");
  a_cont_result: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctl_r.en && ctl_r.mode == mode_cont) |=> result_r == $past(cmp_low))
    else $error("Continuous result not tracking.");
  a_debug_halt: assert property (@(posedge clk_i) disable iff (rst_i)
    (debug_i && !clk_r.debug_run && ctl_r.mode != mode_cont) |=> $stable(per_r))
    else $error("Interval advanced in debug.");
  a_reset_key: assert property (@(posedge clk_i) disable iff (rst_i)
    (low_event && ctl_r.rst == `RESET_KEY) |=> sys_rst_o)
    else $error("Reset not raised.");
  a_event_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    low_event |=> flag_r)
    else $error("Event did not set flag.");
  a_count_need: assert property (@(posedge clk_i) disable iff (rst_i)
    (low_event && ctl_r.mode != mode_cont) |-> hits_r + 4'h1 >= hits_need)
    else $error("Intermittent event too early.");

  // Halted ticks must freeze the interval, while debug-run keeps it moving.
  a_sleep_halt: assert property (@(posedge clk_i) disable iff (rst_i)
    (sleep_stop_i && ctl_r.en && ctl_r.mode != mode_cont) |=> $stable(per_r))
    else $error("Interval advanced in sleep.");
  a_debug_run: assert property (@(posedge clk_i) disable iff (rst_i)
    (debug_i && clk_r.debug_run && !sleep_stop_i && det_tick_i && ctl_r.en &&
     ctl_r.mode != mode_cont) |=> per_r != $past(per_r))
    else $error("Interval stalled in debug with debug-run set.");
  a_result_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctl_r.mode != mode_cont && !tick) |=> $stable(result_r))
    else $error("Intermittent result changed between detections.");

  a_reset_no_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctl_r.rst == `RESET_KEY) |=> !irq_o)
    else $error("Interrupt raised while reset issue is chosen.");
  a_irq_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    (flag_r && irq_en_r && ctl_r.rst != `RESET_KEY) |=> irq_o)
    else $error("Interrupt missing with flag and enable set.");
  a_flag_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_i && addr_i == `ADDR_FLAG && wdata_i[`FLAG_IF_POS] && !low_event) |=> !flag_r)
    else $error("Flag not cleared by a write of one.");
  a_count_eight: assert property (@(posedge clk_i) disable iff (rst_i)
    (low_event && ctl_r.mode != mode_cont && ctl_r.cnt == 2'h3) |-> hits_r >= 4'h7)
    else $error("Eight-count event before seven earlier hits.");

  a_thr_copy: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> thr_o == $past(ctl_r.thr))
    else $error("Threshold output not following its field.");
  a_src_copy: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> (src_ext_o == $past(ctl_r.src) && ext_sel_o == $past(ctl_r.ext)))
    else $error("Source outputs not following their fields.");
  a_clk_locked: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_i && !unlocked && addr_i == `ADDR_CLK) |=> $stable(clk_r))
    else $error("Clock settings changed while locked.");
endmodule : svdet

// ===== rail_model.sv
// Behavioural supply rails and comparator on the far side of the voltage monitor.
// Assumes rail levels are given on the same 5-bit scale as the threshold code.
`timescale 1ns/100ps
module rail_model (
  // Selection from the block.
  input wire logic [4:0] thr_i,
  input wire logic src_ext_i,
  input wire logic ext_sel_i,
  // Rail levels set by the bench.
  input wire logic [4:0] vdd_i,
  input wire logic [4:0] ext0_i,
  input wire logic [4:0] ext1_i,
  // Comparator level.
  output logic cmp_low_o
);
  logic [4:0] rail;
  assign rail = src_ext_i ? (ext_sel_i ? ext1_i : ext0_i) : vdd_i;
  assign cmp_low_o = rail < thr_i;
endmodule : rail_model

// ===== svdet_test.sv
// Self-checking bench of the voltage monitor control block with a rail model.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/100ps
`include "svdet_consts.svh"
module svdet_test;
  import svdet_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic det_tick_i = 1'b0;
  logic sleep_stop_i = 1'b0;
  logic debug_i = 1'b0;
  logic [4:0] vdd = 5'h1f;
  logic [4:0] ext0 = 5'h1f;
  logic [4:0] ext1 = 5'h1f;
  logic cmp_low, cmp_on_o, src_ext_o, ext_sel_o, irq_o, sys_rst_o;
  logic [15:0] rdata_o, d;
  logic [4:0] thr_o;
  logic [1:0] clk_src_o;
  logic [2:0] clk_div_o;
  int miscompares = 0;
  int tests_run = 0;
  int n, p, c;
  bit low;
  svdet svdet_i (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .det_tick_i(det_tick_i),
    .sleep_stop_i(sleep_stop_i), .debug_i(debug_i), .cmp_low_i(cmp_low),
    .cmp_on_o(cmp_on_o), .thr_o(thr_o), .src_ext_o(src_ext_o), .ext_sel_o(ext_sel_o),
    .clk_src_o(clk_src_o), .clk_div_o(clk_div_o), .irq_o(irq_o), .sys_rst_o(sys_rst_o));
  rail_model rail_model_i (.thr_i(thr_o), .src_ext_i(src_ext_o), .ext_sel_i(ext_sel_o),
    .vdd_i(vdd), .ext0_i(ext0), .ext1_i(ext1), .cmp_low_o(cmp_low));
  always #50 clk_i = ~clk_i;
  // The detector tick runs at half the bus clock to keep intermittent runs short.
  always @(posedge clk_i) det_tick_i <= ~det_tick_i;
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask : rd
  task automatic cfg(input logic [3:0] a, input logic [15:0] v);
    wr(`ADDR_PROT, `UNLOCK_KEY);
    wr(a, v);
    wr(`ADDR_PROT, 16'h0000);
  endtask : cfg
  // Bounded wait for irq_o or sys_rst_o; running out ends the run.
  task automatic wait_hi(input bit rst, input int lim, output int k);
    k = 0;
    while ((rst ? sys_rst_o : irq_o) !== 1'b1 && k < lim) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    if ((rst ? sys_rst_o : irq_o) !== 1'b1) begin
      miscompares++;
      $display("unexpected event wait: expected high seen low");
      summarize();
    end
  endtask : wait_hi
  task automatic recover(input int w);
    vdd <= 5'h1f;
    ext0 <= 5'h1f;
    ext1 <= 5'h1f;
    repeat (w) @(posedge clk_i);
    wr(`ADDR_FLAG, 16'h0001);
    wr(`ADDR_IRQEN, 16'h0001);
  endtask : recover
  function automatic logic [15:0] ctl(logic s, logic [1:0] k, logic [4:0] t, logic [3:0] r,
      logic x, logic [1:0] m);
    ctl_s v;
    v = '{s, k, t, r, x, mode_e'(m), 1'b1};
    return v;
  endfunction : ctl
  function automatic int period(int m);
    return 2 * (64 << m);
  endfunction : period
  initial begin
    void'($urandom(32'h8ecc));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("thr_o", 16'(thr_o), 16'h001e);
    rd(`ADDR_CLK, d);
    chk("clk reset", d, 16'h0100);
    rd(`ADDR_CTL, d);
    chk("ctl reset", d, 16'h1e00);
    rd(4'hf, d);
    chk("unmapped", d, 16'h0000);
    wr(`ADDR_CTL, 16'h0301);
    rd(`ADDR_CTL, d);
    chk("locked ctl", d, 16'h1e00);
    cfg(`ADDR_CLK, 16'hfe63);
    wr(`ADDR_CLK, 16'h0000);
    rd(`ADDR_CLK, d);
    chk("clk write", d, 16'h0063);
    chk("clk_src_o", 16'(clk_src_o), 16'h0003);
    chk("clk_div_o", 16'(clk_div_o), 16'h0006);
    $display("test registers done");
    recover(2);
    for (int i = 0; i < 16; i++) begin
      wdata_i <= 16'($urandom);
      c = (i < 2) ? 0 : $urandom;
      cfg(`ADDR_CTL, ctl(c[1], 2'h0, (i == 0) ? 5'h00 : (i == 1) ? 5'h1f : 5'($urandom),
        4'h0, c[2], 2'h0));
      // Rails drop only after the new setting lands, so the old one cannot set the flag.
      vdd <= (i == 0) ? 5'h00 : 5'($urandom);
      ext0 <= 5'($urandom);
      ext1 <= 5'($urandom);
      repeat (8) @(posedge clk_i);
      low = (c[1] ? (c[2] ? ext1 : ext0) : vdd) < thr_o;
      rd(`ADDR_FLAG, d);
      chk("result", d, {14'h0, low, low});
      chk("irq", 16'(irq_o), 16'(low));
      chk("cmp_on_o", 16'(cmp_on_o), 16'h0001);
      recover(8);
      rd(`ADDR_FLAG, d);
      chk("cleared", d, 16'h0000);
    end
    $display("test continuous done");
    vdd <= 5'h00;
    cfg(`ADDR_CTL, ctl(1'b0, 2'h0, 5'h10, 4'ha, 1'b0, 2'h1));
    wait_hi(1'b1, period(1) + 16, n);
    chk("irq under reset", 16'(irq_o), 16'h0000);
    rd(`ADDR_CTL, d);
    chk("ctl after reset", d, ctl(1'b0, 2'h0, 5'h10, 4'ha, 1'b0, 2'h0));
    rd(`ADDR_IRQEN, d);
    chk("irq enable after reset", d, 16'h0000);
    recover(16);
    chk("reset released", 16'(sys_rst_o), 16'h0000);
    $display("test reset done");
    for (int m = 1; m < 4; m++) begin
      for (int k = 0; k < 4; k++) begin
        p = period(m);
        recover(p + 16);
        cfg(`ADDR_CTL, ctl(1'b0, 2'(k), 5'h10, 4'h0, 1'b0, 2'(m)));
        if (m == 1 && k == 0) chk("cmp_on_o idle", 16'(cmp_on_o), 16'h0000);
        vdd <= 5'h00;
        wait_hi(1'b0, (1 << k) * p + 16, n);
        chk("count early", 16'(n > ((1 << k) - 1) * p - 8), 16'h0001);
      end
    end
    $display("test intermittent done");
    for (int k = 0; k < 3; k++) begin
      recover(period(3) + 16);
      cfg(`ADDR_CLK, (k == 2) ? 16'h0100 : 16'h0000);
      debug_i <= (k != 1);
      sleep_stop_i <= (k == 1);
      vdd <= 5'h00;
      cfg(`ADDR_CTL, ctl(1'b0, 2'h0, 5'h10, 4'h0, 1'b0, 2'h1));
      repeat (600) @(posedge clk_i);
      chk("gated irq", 16'(irq_o), 16'(k == 2));
      debug_i <= 1'b0;
      sleep_stop_i <= 1'b0;
      wait_hi(1'b0, period(1) + 16, n);
    end
    recover(period(1) + 16);
    sleep_stop_i <= 1'b1;
    vdd <= 5'h00;
    cfg(`ADDR_CTL, ctl(1'b0, 2'h0, 5'h10, 4'h0, 1'b0, 2'h0));
    wait_hi(1'b0, 12, n);
    chk("continuous asleep", 16'(irq_o), 16'h0001);
    $display("test gating done");
    sleep_stop_i <= 1'b0;
    cfg(`ADDR_CTL, ctl(1'b0, 2'h0, 5'h10, 4'h0, 1'b0, 2'h0) & 16'hfffe);
    recover(8);
    vdd <= 5'h00;
    repeat (12) @(posedge clk_i);
    rd(`ADDR_FLAG, d);
    chk("stopped flag", d & 16'h0001, 16'h0000);
    chk("stopped irq", 16'(irq_o), 16'h0000);
    chk("stopped cmp_on_o", 16'(cmp_on_o), 16'h0000);
    $display("test stop done");
    summarize();
  end
endmodule : svdet_test
